/* aes_byte_order_mapper.sv */
`timescale 1ns/10ps
// What this block does
// - Config bits 2,3 order input text into State
// - Config bits 4,5 order State into result text
// - Input text: plaintext encrypting, ciphertext decrypting
// - Output text: ciphertext encrypting, plaintext decrypting
// - State bytes come only from text register bytes
// - Order 00: column c from word 3-c, MSB row0
// - Order 01: column c from word 3-c, LSB row0
// - Order 10: column c from word c, MSB row0
// - Order 11: column c from word c, LSB row0
// - Key 00: w[i] from key 3-i, bytes kept
// - Key 01: w[i] from key 3-i, bytes reversed
// - Key 10: w[i] from key i, bytes kept
// - Key 11: w[i] from key i, bytes reversed
// - Eight 32-bit key registers provided
// - Completion overwrites text registers with result
// - Three-bit operation field selects direction and size
module aes_byte_order_mapper #(
  parameter int ADDR_WIDTH = 8
) (
  input  wire logic                  core_clk_i,
  input  wire logic                  nrst_i,
  input  wire logic [ADDR_WIDTH-1:0] reg_addr_i,
  input  wire logic [31:0]           reg_wdata_i,
  input  wire logic                  reg_wr_i,
  input  wire logic                  reg_rd_i,
  output logic      [31:0]           reg_rdata_o,
  input  wire logic                  load_i,
  input  wire logic                  done_i,
  input  wire logic [127:0]          result_state_i,
  output logic      [127:0]          state_o,
  output logic      [127:0]          key_words_o,
  output logic      [2:0]            op_mode_o,
  output logic                       decrypt_o,
  output logic                       busy_o
);

  // ****************************************************************
  // State record
  // ****************************************************************
  typedef struct packed {
    logic [5:0]                                    cfg;
    logic [2:0]                                    mode;
    logic [aes_byte_order_pkg::TEXT_WORDS-1:0][31:0] text;
    logic [aes_byte_order_pkg::KEY_WORDS-1:0][31:0]  key;
    logic [127:0]                                  state;
    logic [127:0]                                  keyw;
    logic [31:0]                                   rdata;
    logic                                          busy;
  } regs_t;

  regs_t r_q;
  regs_t r_d;

  // ****************************************************************
  // Byte steering helpers
  // ****************************************************************
  // Word index feeding State column c (or key word i)
  function automatic logic [1:0] word_sel(input logic fwd, input logic [1:0] c);
    word_sel = fwd ? c : (2'h3 - c);
  endfunction

  // Byte of a 32-bit word that lands in row r
  function automatic logic [7:0] row_byte(input logic [31:0] w, input logic swap,
                                          input logic [1:0] r);
    logic [1:0] lane;
    lane = swap ? r : (2'h3 - r);
    row_byte = w[lane*8 +: 8];
  endfunction

  // State byte at (row, column); FIPS order, first byte in the MSBs
  function automatic logic [6:0] st_pos(input logic [1:0] r, input logic [1:0] c);
    st_pos = 7'(127 - 8 * (4 * c + r) - 7);
  endfunction

  function automatic logic [127:0] text_to_state(
      input logic [3:0][31:0] t, input logic [1:0] ord);
    logic [127:0] s;
    s = '0;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        s[st_pos(2'(r), 2'(c)) +: 8] =
          row_byte(t[word_sel(ord[aes_byte_order_pkg::ORDER_FWD_WORD_BIT], 2'(c))],
                   ord[aes_byte_order_pkg::ORDER_SWAP_BIT], 2'(r));
      end
    end
    text_to_state = s;
  endfunction

  // Exact inverse of text_to_state for the same order
  function automatic logic [3:0][31:0] state_to_text(
      input logic [127:0] s, input logic [1:0] ord);
    logic [3:0][31:0] t;
    logic [1:0]       w;
    logic [1:0]       lane;
    t = '0;
    for (int c = 0; c < 4; c++) begin
      for (int r = 0; r < 4; r++) begin
        w    = word_sel(ord[aes_byte_order_pkg::ORDER_FWD_WORD_BIT], 2'(c));
        lane = ord[aes_byte_order_pkg::ORDER_SWAP_BIT] ? 2'(r) : 2'(3 - r);
        t[w][lane*8 +: 8] = s[st_pos(2'(r), 2'(c)) +: 8];
      end
    end
    state_to_text = t;
  endfunction

  function automatic logic [127:0] key_to_words(
      input logic [7:0][31:0] k, input logic [1:0] ord);
    logic [127:0] kw;
    logic [31:0]  src;
    kw = '0;
    for (int i = 0; i < aes_byte_order_pkg::KEY128_WORDS; i++) begin
      src = k[word_sel(ord[aes_byte_order_pkg::ORDER_FWD_WORD_BIT], 2'(i))];
      if (ord[aes_byte_order_pkg::ORDER_SWAP_BIT]) begin
        src = {src[7:0], src[15:8], src[23:16], src[31:24]};
      end
      kw[127 - 32 * i -: 32] = src;
    end
    key_to_words = kw;
  endfunction

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  logic [1:0]   key_ord;
  logic [1:0]   in_ord;
  logic [1:0]   out_ord;
  logic [ADDR_WIDTH-1:0] a_word;
  logic         mode_valid;

  assign key_ord = r_q.cfg[aes_byte_order_pkg::KEY_ORDER_LSB +: 2];
  assign in_ord  = r_q.cfg[aes_byte_order_pkg::IN_ORDER_LSB +: 2];
  assign out_ord = r_q.cfg[aes_byte_order_pkg::OUT_ORDER_LSB +: 2];
  assign a_word  = reg_addr_i;
  assign mode_valid = (r_q.mode != aes_byte_order_pkg::OP_RSVD_3) &&
                      (r_q.mode != aes_byte_order_pkg::OP_RSVD_7);

  always_comb begin
    r_d = r_q;
    r_d.rdata = '0;

    // Software writes
    if (reg_wr_i) begin
      if (a_word >= ADDR_WIDTH'(aes_byte_order_pkg::TEXT_BASE_OFS) &&
          a_word <  ADDR_WIDTH'(aes_byte_order_pkg::KEY_BASE_OFS) && a_word[1:0] == 2'h0) begin
        r_d.text[a_word[3:2]] = reg_wdata_i;
      end else if (a_word >= ADDR_WIDTH'(aes_byte_order_pkg::KEY_BASE_OFS) &&
                   a_word <  ADDR_WIDTH'(aes_byte_order_pkg::MODE_OFS) &&
                   a_word[1:0] == 2'h0) begin
        r_d.key[3'(a_word[4:2] - 3'h4)] = reg_wdata_i;
      end else if (a_word == ADDR_WIDTH'(aes_byte_order_pkg::MODE_OFS)) begin
        r_d.mode = reg_wdata_i[aes_byte_order_pkg::MODE_WIDTH-1:0];
      end else if (a_word == ADDR_WIDTH'(aes_byte_order_pkg::BYTE_ORDER_CFG_OFS)) begin
        r_d.cfg = reg_wdata_i[aes_byte_order_pkg::CFG_WIDTH-1:0];
      end
    end

    // Reads: data appear in the following cycle only
    if (reg_rd_i) begin
      if (a_word >= ADDR_WIDTH'(aes_byte_order_pkg::TEXT_BASE_OFS) &&
          a_word <  ADDR_WIDTH'(aes_byte_order_pkg::KEY_BASE_OFS) && a_word[1:0] == 2'h0) begin
        r_d.rdata = r_q.text[a_word[3:2]];
      end else if (a_word >= ADDR_WIDTH'(aes_byte_order_pkg::KEY_BASE_OFS) &&
                   a_word <  ADDR_WIDTH'(aes_byte_order_pkg::MODE_OFS) &&
                   a_word[1:0] == 2'h0) begin
        r_d.rdata = r_q.key[3'(a_word[4:2] - 3'h4)];
      end else if (a_word == ADDR_WIDTH'(aes_byte_order_pkg::MODE_OFS)) begin
        r_d.rdata = {29'h0000_0000, r_q.mode};
      end else if (a_word == ADDR_WIDTH'(aes_byte_order_pkg::BYTE_ORDER_CFG_OFS)) begin
        r_d.rdata = {26'h000_0000, r_q.cfg};
      end else if (a_word == ADDR_WIDTH'(aes_byte_order_pkg::STATUS_OFS)) begin
        r_d.rdata[aes_byte_order_pkg::STAT_BUSY_BIT]       = r_q.busy;
        r_d.rdata[aes_byte_order_pkg::STAT_MODE_VALID_BIT] = mode_valid;
      end
    end

    // Load: order bits taken at this edge, text is the operation input
    if (load_i) begin
      r_d.state = text_to_state(r_q.text, in_ord);
      r_d.keyw  = key_to_words(r_q.key, key_ord);
      r_d.busy  = 1'b1;
    end

    // Writeback last, so a completing result beats a same-cycle text write
    if (done_i) begin
      r_d.text = state_to_text(result_state_i, out_ord);
      r_d.busy = 1'b0;
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      r_q.cfg   <= aes_byte_order_pkg::CFG_RST;
      r_q.mode  <= aes_byte_order_pkg::MODE_RST;
      r_q.text  <= '0;
      r_q.key   <= '0;
      r_q.state <= '0;
      r_q.keyw  <= '0;
      r_q.rdata <= aes_byte_order_pkg::WORD_RST;
      r_q.busy  <= 1'b0;
    end else begin
      r_q <= r_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_rdata_o = r_q.rdata;
  assign state_o     = r_q.state;
  assign key_words_o = r_q.keyw;
  assign op_mode_o   = r_q.mode;
  assign decrypt_o   = r_q.mode[aes_byte_order_pkg::MODE_DECRYPT_BIT];
  assign busy_o      = r_q.busy;

endmodule

/* aes_byte_order_pkg.sv */
package aes_byte_order_pkg;

  // ****************************************************************
  // Register map, byte addresses of aligned 32-bit words
  // ****************************************************************
  localparam logic [7:0] TEXT_BASE_OFS       = 8'h00;
  localparam logic [7:0] KEY_BASE_OFS        = 8'h10;
  localparam logic [7:0] MODE_OFS            = 8'h30;
  localparam logic [7:0] BYTE_ORDER_CFG_OFS  = 8'h34;
  localparam logic [7:0] STATUS_OFS          = 8'h38;

  localparam int TEXT_WORDS = 4;
  localparam int KEY_WORDS  = 8;
  localparam int KEY128_WORDS = 4;

  // ****************************************************************
  // Field layout of byte_order_config
  // ****************************************************************
  localparam int KEY_ORDER_LSB = 0;
  localparam int IN_ORDER_LSB  = 2;
  localparam int OUT_ORDER_LSB = 4;
  localparam int CFG_WIDTH     = 6;
  localparam int MODE_WIDTH    = 3;

  // Status bits
  localparam int STAT_BUSY_BIT       = 0;
  localparam int STAT_MODE_VALID_BIT = 1;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [5:0]  CFG_RST  = 6'h00;
  localparam logic [2:0]  MODE_RST = 3'h0;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;

  // ****************************************************************
  // Operation codes and order encodings
  // ****************************************************************
  typedef enum logic [2:0] {
    OP_ENC_128 = 3'b000,
    OP_ENC_192 = 3'b001,
    OP_ENC_256 = 3'b010,
    OP_RSVD_3  = 3'b011,
    OP_DEC_128 = 3'b100,
    OP_DEC_192 = 3'b101,
    OP_DEC_256 = 3'b110,
    OP_RSVD_7  = 3'b111
  } op_mode_t;

  localparam int MODE_DECRYPT_BIT = 2;

  // Upper bit: word order forward; lower bit: bytes reversed in word
  localparam int ORDER_FWD_WORD_BIT = 1;
  localparam int ORDER_SWAP_BIT     = 0;

endpackage

/* aes_byte_order_mapper_monitor.sv */
`timescale 1ns/10ps
// ******
// Port checker, one clock domain
// ******
module aes_byte_order_mapper_monitor #(
  parameter int ADDR_WIDTH = 8
) (
  input wire logic                  core_clk_i,
  input wire logic                  nrst_i,
  input wire logic [ADDR_WIDTH-1:0] reg_addr_i,
  input wire logic [31:0]           reg_wdata_i,
  input wire logic                  reg_wr_i,
  input wire logic                  reg_rd_i,
  input wire logic [31:0]           reg_rdata_o,
  input wire logic                  load_i,
  input wire logic                  done_i,
  input wire logic [127:0]          result_state_i,
  input wire logic [127:0]          state_o,
  input wire logic [127:0]          key_words_o,
  input wire logic [2:0]            op_mode_o,
  input wire logic                  decrypt_o,
  input wire logic                  busy_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  property p_busy_set; load_i && !done_i |=> busy_o; endproperty
  a_busy_set: assert property (p_busy_set) else $error("busy not set by load");
  property p_busy_clr; done_i |=> !busy_o; endproperty
  a_busy_clr: assert property (p_busy_clr) else $error("busy not cleared by done");
  property p_state_hold; !load_i |=> $stable(state_o); endproperty
  a_state_hold: assert property (p_state_hold) else $error("state moved without load");
  property p_key_hold; !load_i |=> $stable(key_words_o); endproperty
  a_key_hold: assert property (p_key_hold) else $error("key moved without load");
  property p_rd_idle; !reg_rd_i |=> reg_rdata_o == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_dec_bit; ##1 decrypt_o == op_mode_o[2]; endproperty
  a_dec_bit: assert property (p_dec_bit) else $error("direction differs from mode");
  property p_mode_rd;
    reg_rd_i && reg_addr_i == aes_byte_order_pkg::MODE_OFS |=> reg_rdata_o == 32'(op_mode_o);
  endproperty
  a_mode_rd: assert property (p_mode_rd) else $error("mode readback differs");
  property p_cfg_rd;
    reg_rd_i && reg_addr_i == aes_byte_order_pkg::BYTE_ORDER_CFG_OFS |=>
      reg_rdata_o[31:6] == 26'h0;
  endproperty
  a_cfg_rd: assert property (p_cfg_rd) else $error("config upper bits set");
  c_load: cover property (load_i ##1 busy_o);
  c_done: cover property (busy_o ##1 done_i);
  c_both: cover property (done_i && reg_wr_i);
endmodule

bind aes_byte_order_mapper aes_byte_order_mapper_monitor #(.ADDR_WIDTH(ADDR_WIDTH)) u_mon (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .load_i(load_i), .done_i(done_i),
  .result_state_i(result_state_i), .state_o(state_o), .key_words_o(key_words_o),
  .op_mode_o(op_mode_o), .decrypt_o(decrypt_o), .busy_o(busy_o));

/* tb_top.sv */
`timescale 1ns/10ps
// ******
// Bench: bus driver, queued expectations, output watcher
// ******
module tb_top;
  logic                core_clk_i = 1'b0;
  logic                nrst_i = 1'b0;
  logic [7:0]          reg_addr_i = 8'h00;
  logic [31:0]         reg_wdata_i = 32'h0;
  logic                reg_wr_i = 1'b0;
  logic                reg_rd_i = 1'b0;
  logic                load_i = 1'b0;
  logic                done_i = 1'b0;
  logic [127:0]        result_state_i = 128'h0;
  logic [31:0]         reg_rdata_o;
  logic [127:0]        state_o;
  logic [127:0]        key_words_o;
  logic [2:0]          op_mode_o;
  logic                decrypt_o;
  logic                busy_o;
  logic                rd_seen = 1'b0;
  logic                ld_seen = 1'b0;
  logic [31:0]         exp_rd[$];
  logic [127:0]        exp_st[$];
  logic [127:0]        exp_key[$];
  logic [3:0][31:0]    txt;
  logic [7:0][31:0]    key;
  logic [5:0]          cfg;
  logic [2:0]          mode;
  logic [127:0]        res;
  logic [31:0]         seed = 32'h14;
  logic [2:0]          modes[6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
  int                  errors = 0;
  int                  tests_run = 0;
  int                  n, i, r, c;
  localparam logic [7:0] TB = aes_byte_order_pkg::TEXT_BASE_OFS;
  localparam logic [7:0] KB = aes_byte_order_pkg::KEY_BASE_OFS;

  aes_byte_order_mapper dut (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .load_i(load_i), .done_i(done_i),
    .result_state_i(result_state_i), .state_o(state_o), .key_words_o(key_words_o),
    .op_mode_o(op_mode_o), .decrypt_o(decrypt_o), .busy_o(busy_o));

  always #5 core_clk_i = ~core_clk_i;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [127:0] to_state(input logic [3:0][31:0] t, input logic [1:0] o);
    logic [127:0] s;
    for (int cc = 0; cc < 4; cc++)
      for (int rr = 0; rr < 4; rr++)
        s[127-8*(4*cc+rr) -: 8] = t[o[1] ? cc : 3-cc][8*(o[0] ? rr : 3-rr) +: 8];
    return s;
  endfunction
  function automatic logic [127:0] to_key(input logic [3:0][31:0] k, input logic [1:0] o);
    logic [127:0] s;
    logic [31:0]  w;
    for (int ii = 0; ii < 4; ii++) begin
      w = k[o[1] ? ii : 3-ii];
      s[127-32*ii -: 32] = o[0] ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
    end
    return s;
  endfunction
  task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] s);
    tests_run++;
    if (e !== s) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask
  // One bus/datapath cycle; read expectations queue for the watcher
  task automatic acc(input logic w, rd, ld, dn, input logic [7:0] a, input logic [31:0] d);
    reg_wr_i <= w;
    reg_rd_i <= rd;
    load_i <= ld;
    done_i <= dn;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    if (rd) exp_rd.push_back(d);
    @(posedge core_clk_i);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // Outputs sampled mid-cycle, clear of edge races
  always @(posedge core_clk_i) begin
    rd_seen <= reg_rd_i;
    ld_seen <= load_i;
  end
  always @(negedge core_clk_i) begin
    if (rd_seen) chk("rdata", 128'(exp_rd.pop_front()), 128'(reg_rdata_o));
    if (ld_seen) chk("state", exp_st.pop_front(), state_o);
    if (ld_seen) chk("key", exp_key.pop_front(), key_words_o);
  end

  initial begin
    #20000;
    errors++;
    final_report;
  end

  initial begin
    repeat (2) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    for (n = 0; n < 6; n++) begin
      mode = modes[n];
      cfg = {2'(n), 2'(n + 1), 2'(n + 2)};
      for (i = 0; i < 8; i++) begin
        seed = lfsr(seed);
        key[i] = seed;
        txt[i % 4] = ~seed;
        acc(1'b1, 1'b0, 1'b0, 1'b0, KB + 8'(4 * i), key[i]);
      end
      for (i = 0; i < 4; i++) acc(1'b1, 1'b0, 1'b0, 1'b0, TB + 8'(4 * i), txt[i]);
      acc(1'b1, 1'b0, 1'b0, 1'b0, aes_byte_order_pkg::BYTE_ORDER_CFG_OFS, 32'(cfg));
      acc(1'b1, 1'b0, 1'b0, 1'b0, aes_byte_order_pkg::MODE_OFS, 32'(mode));
      acc(1'b0, 1'b1, 1'b0, 1'b0, aes_byte_order_pkg::BYTE_ORDER_CFG_OFS, 32'(cfg));
      acc(1'b0, 1'b1, 1'b0, 1'b0, aes_byte_order_pkg::MODE_OFS, 32'(mode));
      acc(1'b0, 1'b1, 1'b0, 1'b0, KB + 8'h1c, key[7]);
      acc(1'b0, 1'b1, 1'b0, 1'b0, 8'h3c, 32'h0);
      exp_st.push_back(to_state(txt, cfg[3:2]));
      exp_key.push_back(to_key(key[3:0], cfg[1:0]));
      acc(1'b0, 1'b0, 1'b1, 1'b0, 8'h00, 32'h0);
      acc(1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 32'h0);
      chk("busy", 128'(1'b1), 128'(busy_o));
      chk("decrypt", 128'(mode[2]), 128'(decrypt_o));
      acc(1'b0, 1'b1, 1'b0, 1'b0, aes_byte_order_pkg::STATUS_OFS, 32'h3);
      res = {lfsr(seed), ~seed, seed ^ 32'h5a5a_5a5a, seed[15:0], seed[31:16]};
      result_state_i <= res;
      // Software write in the writeback cycle must lose
      acc(1'b1, 1'b0, 1'b0, 1'b1, TB, ~txt[0]);
      for (c = 0; c < 4; c++)
        for (r = 0; r < 4; r++)
          txt[cfg[5] ? c : 3-c][8*(cfg[4] ? r : 3-r) +: 8] = res[127-8*(4*c+r) -: 8];
      for (i = 0; i < 4; i++) acc(1'b0, 1'b1, 1'b0, 1'b0, TB + 8'(4 * i), txt[i]);
      acc(1'b0, 1'b1, 1'b0, 1'b0, aes_byte_order_pkg::STATUS_OFS, 32'h2);
    end
    acc(1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 32'h0);
    acc(1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 32'h0);
    final_report;
  end
endmodule
